// File: rtl/tx_emul_defs.vh
`ifndef TX_EMUL_DEFS_VH
`define TX_EMUL_DEFS_VH

// register addresses on the deframed register port
`define ADDR_CAPACITOR_CONFIG   8'h01
`define ADDR_EMULATION_CONFIG   8'h02

// reset values
`define RST_CAPACITOR_CONFIG    8'h00
`define RST_EMULATION_CONFIG    8'h00

// emulation_config field positions
`define EMU_EN_BIT              7
`define EMU_MOD_BIT             6
`define EMU_PWR_HI_BIT          5
`define EMU_PWR_LO_BIT          4
`define EMU_DEV_BIT             3
`define EMU_FRQ_MSB             2
`define EMU_FRQ_LSB             0

// capacitor_config field positions
`define CAP_MSB                 4
`define CAP_LSB                 0

// power step attenuation, dB below maximum
`define PWR_DB_STEP0            4'h0
`define PWR_DB_STEP1            4'h3
`define PWR_DB_STEP2            4'h6
`define PWR_DB_STEP3            4'ha

// fsk deviation, kHz either side of the carrier
`define DEV_KHZ_NARROW          6'h10
`define DEV_KHZ_WIDE            6'h32

// largest capacitor code a pulse train can reach
`define CAP_CODE_MAX            5'h1f

`endif

// File: rtl/pulse_cap_loader.v
`timescale 1ns/1ps
`include "tx_emul_defs.vh"

// counts data-pin pulses after the first while enable is low; enable rising edge commits
module pulse_cap_loader (
    input  wire       clk,
    input  wire       rst,
    input  wire       enable_pin,
    input  wire       din_pin,
    input  wire [2:0] freq_now,
    output reg  [4:0] loaded_code,
    output reg  [2:0] loaded_freq,
    output reg        loaded_valid
);
    localparam [1:0] ST_WAIT  = 2'b01;
    localparam [1:0] ST_COUNT = 2'b10;

    reg  [1:0] state;
    reg        din_prev;
    reg        enable_prev;
    reg  [4:0] count;
    reg  [2:0] freq_latch;
    wire       din_rise    = din_pin & ~din_prev;
    wire       enable_rise = enable_pin & ~enable_prev;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state        <= ST_WAIT;
            din_prev     <= 1'b0;
            enable_prev  <= 1'b1;           // pin idles high, no false rise after reset
            count        <= 5'h00;
            freq_latch   <= 3'h0;
            loaded_code  <= 5'h00;
            loaded_freq  <= 3'h0;
            loaded_valid <= 1'b0;
        end else begin
            din_prev    <= din_pin;
            enable_prev <= enable_pin;
            case (state)
                ST_WAIT: begin
                    if (!enable_pin && din_rise) begin
                        count      <= 5'h00;
                        freq_latch <= freq_now;
                        state      <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (enable_rise) begin
                        loaded_code  <= count;
                        loaded_freq  <= freq_latch;
                        loaded_valid <= 1'b1;
                        state        <= ST_WAIT;
                    end else if (!enable_pin && din_rise && count != `CAP_CODE_MAX) begin
                        count <= count + 5'h01;
                    end
                end
                default: begin
                    state <= ST_WAIT;
                end
            endcase
        end
    end
endmodule

// File: rtl/tx_emulation_mode_config.v
`timescale 1ns/1ps
`include "tx_emul_defs.vh"

module tx_emulation_mode_config (
    input  wire       clk,
    input  wire       rst,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    output reg        reg_rvalid,
    input  wire       enable_pin,
    input  wire       din_pin,
    input  wire       freq_sel_pin_a,
    input  wire       freq_sel_pin_b,
    input  wire       freq_sel_pin_c,
    input  wire       ser_mod_fsk,
    input  wire [1:0] ser_power_step,
    input  wire       ser_dev_wide,
    input  wire [2:0] ser_freq_code,
    output reg        emul_active,
    output reg        mod_fsk,
    output reg  [1:0] power_step,
    output reg  [3:0] power_db_below,
    output reg        dev_wide,
    output reg  [5:0] dev_khz,
    output reg  [2:0] freq_code,
    output reg  [4:0] pa_cap_code,
    output reg        freq_pin_conflict
);
    reg  [7:0] emulation_config;
    reg  [7:0] capacitor_config;

    wire [4:0] loaded_code;
    wire [2:0] loaded_freq;
    wire       loaded_valid;

    reg        next_mod;
    reg  [1:0] next_pwr;
    reg        next_dev;
    reg  [2:0] next_freq;
    reg  [3:0] next_db;
    reg  [4:0] next_cap;
    reg  [7:0] next_rdata;
    reg  [5:0] next_khz;

    wire       emu_on    = emulation_config[`EMU_EN_BIT];
    wire       pins_high = freq_sel_pin_a | freq_sel_pin_b | freq_sel_pin_c;
    wire [4:0] reg_cap   = capacitor_config[`CAP_MSB:`CAP_LSB];

    pulse_cap_loader u_loader (
        .clk          (clk),
        .rst          (rst),
        .enable_pin   (enable_pin),
        .din_pin      (din_pin),
        .freq_now     (next_freq),
        .loaded_code  (loaded_code),
        .loaded_freq  (loaded_freq),
        .loaded_valid (loaded_valid)
    );

    // register file
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            emulation_config <= `RST_EMULATION_CONFIG;
            capacitor_config <= `RST_CAPACITOR_CONFIG;
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_EMULATION_CONFIG) begin
                emulation_config <= reg_wdata;
            end
            if (reg_addr == `ADDR_CAPACITOR_CONFIG) begin
                capacitor_config <= reg_wdata;
            end
        end
    end

    always @* begin
        case (reg_addr)
            `ADDR_EMULATION_CONFIG: next_rdata = emulation_config;
            `ADDR_CAPACITOR_CONFIG: next_rdata = capacitor_config;
            default:                next_rdata = 8'h00;
        endcase
    end

    // setting selection between emulation fields and ordinary serial settings
    always @* begin
        if (emu_on) begin
            next_mod  = emulation_config[`EMU_MOD_BIT];
            next_pwr  = {emulation_config[`EMU_PWR_HI_BIT],
                         emulation_config[`EMU_PWR_LO_BIT]};
            next_dev  = emulation_config[`EMU_DEV_BIT];
            next_freq = emulation_config[`EMU_FRQ_MSB:`EMU_FRQ_LSB];
        end else begin
            next_mod  = ser_mod_fsk;
            next_pwr  = ser_power_step;
            next_dev  = ser_dev_wide;
            next_freq = ser_freq_code;
        end
    end

    always @* begin
        case (next_pwr)
            2'b00:   next_db = `PWR_DB_STEP0;
            2'b01:   next_db = `PWR_DB_STEP1;
            2'b10:   next_db = `PWR_DB_STEP2;
            2'b11:   next_db = `PWR_DB_STEP3;
            default: next_db = `PWR_DB_STEP0;
        endcase
    end

    // capacitor arbitration
    always @* begin
        if (reg_cap != 5'h00) begin
            next_cap = reg_cap;
        end else if (loaded_valid && loaded_freq == next_freq) begin
            next_cap = loaded_code;
        end else begin
            next_cap = 5'h00;
        end
    end

    always @* begin
        case (next_dev)
            1'b0:    next_khz = `DEV_KHZ_NARROW;
            1'b1:    next_khz = `DEV_KHZ_WIDE;
            default: next_khz = `DEV_KHZ_NARROW;
        endcase
    end

    // read port
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= reg_rd ? next_rdata : 8'h00;
            reg_rvalid <= reg_rd;
        end
    end

    // registered outputs
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            emul_active <= 1'b0;
        end else begin
            emul_active <= emu_on;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mod_fsk <= 1'b0;
        end else begin
            mod_fsk <= next_mod;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            power_step <= 2'b00;
        end else begin
            power_step <= next_pwr;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            power_db_below <= `PWR_DB_STEP0;
        end else begin
            power_db_below <= next_db;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dev_wide <= 1'b0;
        end else begin
            dev_wide <= next_dev;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dev_khz <= `DEV_KHZ_NARROW;
        end else begin
            dev_khz <= next_khz;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            freq_code <= 3'h0;
        end else begin
            freq_code <= next_freq;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pa_cap_code <= 5'h00;
        end else begin
            pa_cap_code <= next_cap;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            freq_pin_conflict <= 1'b0;
        end else begin
            freq_pin_conflict <= emu_on & pins_high;
        end
    end
endmodule

// File: testbench/tx_emul_checker.sv
`timescale 1ns/1ps
module tx_emul_checker (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic       reg_rvalid,
    input wire logic       ser_mod_fsk,
    input wire logic       emul_active,
    input wire logic       mod_fsk,
    input wire logic       dev_wide,
    input wire logic [1:0] ser_power_step,
    input wire logic [1:0] power_step,
    input wire logic [2:0] freq_code,
    input wire logic [3:0] power_db_below,
    input wire logic [4:0] pa_cap_code,
    input wire logic [5:0] dev_khz,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire e_wr = reg_wr && reg_addr == 8'h02;
    wire c_wr = reg_wr && reg_addr == 8'h01 && reg_wdata[4:0] != 5'h00;
    a_emul_enter: assert property (e_wr |-> ##2 emul_active == $past(reg_wdata[7], 2))
        else $error("emulation enable wrong");
    a_emul_fields: assert property (e_wr && reg_wdata[7] |-> ##2
        {mod_fsk, power_step, dev_wide, freq_code} == $past(reg_wdata[6:0], 2)) else $error("fields wrong");
    a_serial_path: assert property (!emul_active && !$past(rst) |->
        mod_fsk == $past(ser_mod_fsk) && power_step == $past(ser_power_step)) else $error("serial path wrong");
    a_db_map: assert property (power_db_below == (power_step == 2'h3 ? 4'ha : {2'h0, power_step} * 4'h3))
        else $error("power db wrong");
    a_khz_map: assert property (dev_khz == (dev_wide ? 6'h32 : 6'h10)) else $error("deviation wrong");
    a_cap_wins: assert property (c_wr |-> ##2 pa_cap_code == $past(reg_wdata[4:0], 2))
        else $error("cap code wrong");
    a_read_valid: assert property (reg_rd |=> reg_rvalid) else $error("no read valid");
    a_read_idle: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 8'h00) else $error("idle read");
    a_read_unmapped: assert property (reg_rd && reg_addr != 8'h01 && reg_addr != 8'h02 |=> reg_rdata == 8'h00)
        else $error("unmapped read");
endmodule
bind tx_emulation_mode_config tx_emul_checker i_tx_emul_checker (
    .clk            (clk),
    .rst            (rst),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rvalid     (reg_rvalid),
    .ser_mod_fsk    (ser_mod_fsk),
    .emul_active    (emul_active),
    .mod_fsk        (mod_fsk),
    .dev_wide       (dev_wide),
    .ser_power_step (ser_power_step),
    .power_step     (power_step),
    .freq_code      (freq_code),
    .power_db_below (power_db_below),
    .pa_cap_code    (pa_cap_code),
    .dev_khz        (dev_khz),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_rdata      (reg_rdata)
);

// File: testbench/host_pins.sv
`timescale 1ns/1ps
module host_pins (
    input  wire logic clk,
    input  wire logic fault,
    output logic      enable_pin,
    output logic      din_pin,
    output logic      freq_sel_pin_a,
    output logic      freq_sel_pin_b,
    output logic      freq_sel_pin_c
);
    // pins low in register mode unless a fault is commanded
    assign {freq_sel_pin_a, freq_sel_pin_b, freq_sel_pin_c} = {3{fault}};
    initial {enable_pin, din_pin} = 2'b10;
    task automatic load(input int n);
        @(posedge clk) #10 enable_pin = 0;
        repeat (n) begin
            repeat (2) @(posedge clk);
            #10 din_pin = 1;
            repeat (2) @(posedge clk);
            #10 din_pin = 0;
        end
        @(posedge clk) #10 enable_pin = 1;
        repeat (2) @(posedge clk);
        #10;
    endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`define CMP(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tb_top;
    logic       clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ser_mod_fsk = 0, ser_dev_wide = 0, fault = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [1:0] ser_power_step = 0, power_step;
    logic [2:0] ser_freq_code = 0, freq_code;
    logic [3:0] power_db_below;
    logic [4:0] pa_cap_code;
    logic [5:0] dev_khz;
    logic       reg_rvalid, enable_pin, din_pin, emul_active, mod_fsk, dev_wide, freq_pin_conflict;
    logic       freq_sel_pin_a, freq_sel_pin_b, freq_sel_pin_c;
    int         n_errors = 0, n_compared = 0, seed = 80, cap = 0, emu = 0, lf = 0, pc = 0, pv = 0, e, i, r;
    always #50 clk = ~clk;
    host_pins i_host_pins (
        .clk            (clk),
        .fault          (fault),
        .enable_pin     (enable_pin),
        .din_pin        (din_pin),
        .freq_sel_pin_a (freq_sel_pin_a),
        .freq_sel_pin_b (freq_sel_pin_b),
        .freq_sel_pin_c (freq_sel_pin_c)
    );
    tx_emulation_mode_config i_tx_emulation_mode_config (
        .clk               (clk),
        .rst               (rst),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_rdata         (reg_rdata),
        .reg_rvalid        (reg_rvalid),
        .enable_pin        (enable_pin),
        .din_pin           (din_pin),
        .freq_sel_pin_a    (freq_sel_pin_a),
        .freq_sel_pin_b    (freq_sel_pin_b),
        .freq_sel_pin_c    (freq_sel_pin_c),
        .ser_mod_fsk       (ser_mod_fsk),
        .ser_power_step    (ser_power_step),
        .ser_dev_wide      (ser_dev_wide),
        .ser_freq_code     (ser_freq_code),
        .emul_active       (emul_active),
        .mod_fsk           (mod_fsk),
        .power_step        (power_step),
        .power_db_below    (power_db_below),
        .dev_wide          (dev_wide),
        .dev_khz           (dev_khz),
        .freq_code         (freq_code),
        .pa_cap_code       (pa_cap_code),
        .freq_pin_conflict (freq_pin_conflict)
    );
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic wr(input logic [7:0] a, d);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        cyc(1);
        reg_wr = 0;
        cyc(1);
        if (a == 8'h01) cap = d[4:0];
        if (a == 8'h02) emu = d;
    endtask
    task automatic rd(input logic [7:0] a, x);
        {reg_addr, reg_rd} = {a, 1'b1};
        cyc(1);
        reg_rd = 0;
        `CMP("reg_rdata", x, reg_rdata)
        `CMP("reg_rvalid", 1'b1, reg_rvalid)
        cyc(1);
    endtask
    task automatic chk;
        logic [6:0] m;
        cyc(3);
        m = emu[7] ? emu[6:0] : {ser_mod_fsk, ser_power_step, ser_dev_wide, ser_freq_code};
        `CMP("emul_active", emu[7], emul_active)
        `CMP("mod_fsk", m[6], mod_fsk)
        `CMP("power_step", m[5:4], power_step)
        `CMP("power_db", m[5:4] == 3 ? 10 : m[5:4] * 3, power_db_below)
        `CMP("dev_wide", m[3], dev_wide)
        `CMP("dev_khz", m[3] ? 50 : 16, dev_khz)
        `CMP("freq_code", m[2:0], freq_code)
        `CMP("pa_cap", cap ? cap : (pv && lf == m[2:0]) ? pc : 0, pa_cap_code)
        `CMP("conflict", emu[7] & fault, freq_pin_conflict)
    endtask
    task automatic load(input int n);
        lf = emu[7] ? emu[2:0] : ser_freq_code;
        i_host_pins.load(n);
        pc = n - 1;
        pv = 1;
    endtask
    task automatic conclude;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        cyc(12);
        rst = 0;
        rd(8'h01, 8'h00);
        rd(8'h02, 8'h00);
        for (i = 0; i < 12; i++) begin
            e = i < 8 ? {1'b1, i[0], i[2:1], i[1], i[2:0]} : $random(seed);
            wr(8'h02, e[7:0]);
            r = $random(seed);
            {ser_mod_fsk, ser_power_step, ser_dev_wide, ser_freq_code} = r[6:0];
            chk;
            rd(8'h02, e[7:0]);
        end
        wr(8'h02, 8'h83);
        load(11);
        chk;
        wr(8'h02, 8'h85);
        chk;
        wr(8'h02, 8'h83);
        load(32);
        chk;
        wr(8'h01, 8'h05);
        load(4);
        chk;
        wr(8'h33, 8'hff);
        rd(8'h33, 8'h00);
        fault = 1;
        chk;
        wr(8'h02, 8'h00);
        chk;
        wr(8'h02, 8'hdf);
        rst = 1;
        cyc(2);
        `CMP("rst_emul", 1'b0, emul_active)
        `CMP("rst_khz", 16, dev_khz)
        rst = 0;
        emu = 0;
        cap = 0;
        pv = 0;
        rd(8'h01, 8'h00);
        rd(8'h02, 8'h00);
        chk;
        conclude;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        conclude;
    end
endmodule
